// File: strap_cfg_pkg.sv
package strap_cfg_pkg;

  localparam int GPIO_COUNT = 25;
  localparam int STRAP_COUNT = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // Strap bit positions within the captured byte.
  localparam int SB_VIDEO_FMT = 3;
  localparam int SB_BOOT_SRC = 4;
  localparam int SB_BUS_WIDTH = 5;
  localparam int SB_SEED_MODE = 6;
  localparam int SB_SLAVE_ADDR = 7;

  // General-purpose pin index that carries each strap bit.
  localparam int STRAP_PIN_0 = 5;
  localparam int STRAP_PIN_1 = 13;
  localparam int STRAP_PIN_2 = 1;
  localparam int STRAP_PIN_3 = 0;
  localparam int STRAP_PIN_4 = 21;
  localparam int STRAP_PIN_5 = 2;
  localparam int STRAP_PIN_6 = 3;
  localparam int STRAP_PIN_7 = 12;

  localparam logic [GPIO_COUNT-1:0] DEDICATED_MASK = 25'h0000003;
  localparam logic [GPIO_COUNT-1:0] GPIO_RESET = 25'h0000000;

  localparam logic [7:0] SLAVE_WR_ADDR_0 = 8'he6;
  localparam logic [7:0] SLAVE_RD_ADDR_0 = 8'he7;
  localparam logic [7:0] SLAVE_WR_ADDR_1 = 8'he4;
  localparam logic [7:0] SLAVE_RD_ADDR_1 = 8'he5;

  localparam logic [9:0] ROM_WINDOW_KB = 10'h020;
  localparam logic [9:0] FLASH_WINDOW_KB = 10'h200;

  localparam logic [2:0] CHAN_SINGLE = 3'h1;
  localparam logic [2:0] CHAN_DUAL = 3'h2;
  localparam logic [2:0] CHAN_QUAD = 3'h4;

  localparam logic [ADDR_W-1:0] ADDR_STRAP = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_DIR = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_OD = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_OUT = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_OUT_SET = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_OUT_CLR = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_IN = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_SEL = 8'h20;

  typedef struct packed {
    logic ttl_fmt;
    logic ext_boot;
    logic rom_en;
    logic [9:0] boot_window_kb;
    logic [2:0] channels;
    logic alt_scrambler_seed_en;
    logic [7:0] slave_wr_addr;
    logic [7:0] slave_rd_addr;
  } strap_cfg_type;

  typedef struct packed {
    logic [GPIO_COUNT-1:0] dir;
    logic [GPIO_COUNT-1:0] od;
    logic [GPIO_COUNT-1:0] out;
  } gpio_ctl_type;

  typedef enum logic [1:0] {
    CAP_IN_RESET = 2'b00,
    CAP_SAMPLE = 2'b01,
    CAP_HOLD = 2'b11
  } cap_state_type;

endpackage

// File: strap_capture.sv
`timescale 1ns/1ps
`default_nettype none
module strap_capture import strap_cfg_pkg::*; (
  input wire logic clk_i,
  input wire logic hw_rst_low_i,
  input wire logic [GPIO_COUNT-1:0] pad_in_i,
  output logic [STRAP_COUNT-1:0] raw_o,
  output strap_cfg_type cfg_o,
  output logic valid_o
);

  cap_state_type state_q;
  logic [STRAP_COUNT-1:0] raw_q;
  strap_cfg_type cfg_q;
  strap_cfg_type cfg_d;
  wire [STRAP_COUNT-1:0] pins_w = {pad_in_i[STRAP_PIN_7], pad_in_i[STRAP_PIN_6],
                                   pad_in_i[STRAP_PIN_5], pad_in_i[STRAP_PIN_4],
                                   pad_in_i[STRAP_PIN_3], pad_in_i[STRAP_PIN_2],
                                   pad_in_i[STRAP_PIN_1], pad_in_i[STRAP_PIN_0]};

  assign cfg_d.ttl_fmt = raw_q[SB_VIDEO_FMT];
  assign cfg_d.ext_boot = raw_q[SB_BOOT_SRC];
  assign cfg_d.rom_en = ~raw_q[SB_BOOT_SRC];
  assign cfg_d.boot_window_kb = raw_q[SB_BOOT_SRC] ? FLASH_WINDOW_KB : ROM_WINDOW_KB;
  assign cfg_d.channels = raw_q[SB_VIDEO_FMT] ?
                          (raw_q[SB_BUS_WIDTH] ? CHAN_DUAL : CHAN_SINGLE) :
                          (raw_q[SB_BUS_WIDTH] ? CHAN_QUAD : CHAN_DUAL);
  assign cfg_d.alt_scrambler_seed_en = raw_q[SB_SEED_MODE];
  assign cfg_d.slave_wr_addr = raw_q[SB_SLAVE_ADDR] ? SLAVE_WR_ADDR_1 : SLAVE_WR_ADDR_0;
  assign cfg_d.slave_rd_addr = raw_q[SB_SLAVE_ADDR] ? SLAVE_RD_ADDR_1 : SLAVE_RD_ADDR_0;

  always_ff @(posedge clk_i) begin
    if (!hw_rst_low_i) begin
      state_q <= CAP_IN_RESET;
      raw_q <= '0;
      cfg_q <= '0;
    end else begin
      case (state_q)
        CAP_IN_RESET: begin
          raw_q <= pins_w;
          state_q <= CAP_SAMPLE;
        end
        CAP_SAMPLE: begin
          cfg_q <= cfg_d;
          state_q <= CAP_HOLD;
        end
        CAP_HOLD: state_q <= CAP_HOLD;
        default: state_q <= CAP_IN_RESET;
      endcase
    end
  end

  assign raw_o = raw_q;
  assign cfg_o = cfg_q;
  assign valid_o = (state_q == CAP_HOLD);

endmodule
`default_nettype wire

// File: gpio_pad_bank.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_pad_bank import strap_cfg_pkg::*; #(
  parameter int PINS = GPIO_COUNT
) (
  input wire logic clk_i,
  input wire logic hw_rst_low_i,
  input wire logic drive_en_i,
  input wire logic [PINS-1:0] gpio_sel_i,
  input wire logic [PINS-1:0] dir_i,
  input wire logic [PINS-1:0] od_i,
  input wire logic [PINS-1:0] out_i,
  input wire logic [PINS-1:0] func_out_i,
  input wire logic [PINS-1:0] func_oe_i,
  output logic [PINS-1:0] pad_out_o,
  output logic [PINS-1:0] pad_oe_o
);

  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : pin
      logic out_q;
      logic oe_q;
      // Open drain only pulls low; a high level comes from the board pull-up.
      wire gp_oe = dir_i[g] & (~od_i[g] | ~out_i[g]);
      wire gp_out = out_i[g] & ~od_i[g];
      wire oe_d = drive_en_i & (gpio_sel_i[g] ? gp_oe : func_oe_i[g]);
      wire out_d = gpio_sel_i[g] ? gp_out : func_out_i[g];
      always_ff @(posedge clk_i) begin
        if (!hw_rst_low_i) begin
          out_q <= 1'b0;
          oe_q <= 1'b0;
        end else begin
          out_q <= out_d;
          oe_q <= oe_d;
        end
      end
      assign pad_out_o[g] = out_q;
      assign pad_oe_o[g] = oe_q;
    end
  endgenerate

endmodule
`default_nettype wire

// File: strap_latch_and_gpio_config.sv
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module strap_latch_and_gpio_config import strap_cfg_pkg::*; (
  input wire logic clk_i,
  input wire logic hw_rst_low_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic [GPIO_COUNT-1:0] pad_in_i,
  output logic [GPIO_COUNT-1:0] pad_out_o,
  output logic [GPIO_COUNT-1:0] pad_oe_o,
  input wire logic [GPIO_COUNT-1:0] fw_claim_i,
  input wire logic [GPIO_COUNT-1:0] func_out_i,
  input wire logic [GPIO_COUNT-1:0] func_oe_i,
  output logic [GPIO_COUNT-1:0] func_in_o,
  output logic [GPIO_COUNT-1:0] gpio_in_o,
  output logic ttl_fmt_o,
  output logic ext_boot_o,
  output logic rom_en_o,
  output logic [9:0] boot_window_kb_o,
  output logic [2:0] channels_o,
  output logic alt_scrambler_seed_en_o,
  output logic [7:0] slave_wr_addr_o,
  output logic [7:0] slave_rd_addr_o,
  output logic cfg_valid_o
);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ref_a);
    hit = (a == ref_a);
  endfunction

  function automatic logic [DATA_W-1:0] widen(input logic [GPIO_COUNT-1:0] v);
    widen = {{(DATA_W-GPIO_COUNT){1'b0}}, v};
  endfunction

  logic [STRAP_COUNT-1:0] raw_w;
  strap_cfg_type cfg_w;
  logic valid_w;

  gpio_ctl_type ctl_q;
  gpio_ctl_type ctl_d;
  logic [GPIO_COUNT-1:0] sel_q;
  logic [GPIO_COUNT-1:0] in_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic cfg_valid_q;
  strap_cfg_type cfg_q;

  strap_capture u_capture (
    .clk_i(clk_i),
    .hw_rst_low_i(hw_rst_low_i),
    .pad_in_i(pad_in_i),
    .raw_o(raw_w),
    .cfg_o(cfg_w),
    .valid_o(valid_w)
  );

  wire [GPIO_COUNT-1:0] sel_d = DEDICATED_MASK | fw_claim_i;

  wire [GPIO_COUNT-1:0] wr_bits = wdata_i[GPIO_COUNT-1:0];
  wire wr_dir = wr_i & hit(addr_i, ADDR_DIR);
  wire wr_od = wr_i & hit(addr_i, ADDR_OD);
  wire wr_out = wr_i & hit(addr_i, ADDR_OUT);
  wire wr_set = wr_i & hit(addr_i, ADDR_OUT_SET);
  wire wr_clr = wr_i & hit(addr_i, ADDR_OUT_CLR);

  // Bits of pins the host does not own keep their value, so a later claim
  // by firmware does not inherit stale host writes.
  // mask host writes
  assign ctl_d.dir = wr_dir ? ((ctl_q.dir & ~sel_q) | (wr_bits & sel_q)) : ctl_q.dir;
  assign ctl_d.od = wr_od ? ((ctl_q.od & ~sel_q) | (wr_bits & sel_q)) : ctl_q.od;
  assign ctl_d.out = wr_out ? ((ctl_q.out & ~sel_q) | (wr_bits & sel_q)) :
                     wr_set ? (ctl_q.out | (wr_bits & sel_q)) :
                     wr_clr ? (ctl_q.out & ~(wr_bits & sel_q)) : ctl_q.out;

  wire [DATA_W-1:0] strap_word = {{(DATA_W-STRAP_COUNT-1){1'b0}}, valid_w, raw_w};
  wire [DATA_W-1:0] cfg_word = {1'b0, cfg_w.ttl_fmt, cfg_w.ext_boot, cfg_w.rom_en,
                                cfg_w.boot_window_kb, cfg_w.channels,
                                cfg_w.alt_scrambler_seed_en, cfg_w.slave_wr_addr,
                                2'b00, cfg_w.slave_rd_addr[3:0]};

  assign rdata_d = !rd_i ? '0 :
                   hit(addr_i, ADDR_STRAP) ? strap_word :
                   hit(addr_i, ADDR_CFG) ? cfg_word :
                   hit(addr_i, ADDR_DIR) ? widen(ctl_q.dir) :
                   hit(addr_i, ADDR_OD) ? widen(ctl_q.od) :
                   hit(addr_i, ADDR_OUT) ? widen(ctl_q.out) :
                   hit(addr_i, ADDR_IN) ? widen(in_q) :
                   hit(addr_i, ADDR_SEL) ? widen(sel_q) : '0;

  always_ff @(posedge clk_i) begin
    if (!hw_rst_low_i) begin
      ctl_q <= '{dir: GPIO_RESET, od: GPIO_RESET, out: GPIO_RESET};
      sel_q <= DEDICATED_MASK;
      in_q <= '0;
      rdata_q <= '0;
    end else begin
      ctl_q <= ctl_d;
      sel_q <= sel_d;
      in_q <= pad_in_i;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!hw_rst_low_i) begin
      cfg_q <= '0;
      cfg_valid_q <= 1'b0;
    end else begin
      cfg_q <= cfg_w;
      cfg_valid_q <= valid_w;
    end
  end

  // Pads stay undriven until the straps are held, so board resistors set
  // the strap levels without contention during sampling.
  // drive pads
  gpio_pad_bank #(.PINS(GPIO_COUNT)) u_pads (
    .clk_i(clk_i),
    .hw_rst_low_i(hw_rst_low_i),
    .drive_en_i(valid_w),
    .gpio_sel_i(sel_q),
    .dir_i(ctl_q.dir),
    .od_i(ctl_q.od),
    .out_i(ctl_q.out),
    .func_out_i(func_out_i),
    .func_oe_i(func_oe_i),
    .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o)
  );

  assign rdata_o = rdata_q;
  assign gpio_in_o = in_q;
  assign func_in_o = in_q;
  assign ttl_fmt_o = cfg_q.ttl_fmt;
  assign ext_boot_o = cfg_q.ext_boot;
  assign rom_en_o = cfg_q.rom_en;
  assign boot_window_kb_o = cfg_q.boot_window_kb;
  assign channels_o = cfg_q.channels;
  assign alt_scrambler_seed_en_o = cfg_q.alt_scrambler_seed_en;
  assign slave_wr_addr_o = cfg_q.slave_wr_addr;
  assign slave_rd_addr_o = cfg_q.slave_rd_addr;
  assign cfg_valid_o = cfg_valid_q;

endmodule
`default_nettype wire

// File: strap_cfg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module strap_cfg_chk import strap_cfg_pkg::*; (
  input wire logic clk_i,
  input wire logic hw_rst_low_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [GPIO_COUNT-1:0] pad_in_i,
  input wire logic [GPIO_COUNT-1:0] pad_oe_o,
  input wire logic [GPIO_COUNT-1:0] fw_claim_i,
  input wire logic [GPIO_COUNT-1:0] func_oe_i,
  input wire logic ttl_fmt_o,
  input wire logic ext_boot_o,
  input wire logic rom_en_o,
  input wire logic [9:0] boot_window_kb_o,
  input wire logic [2:0] channels_o,
  input wire logic alt_scrambler_seed_en_o,
  input wire logic [7:0] slave_wr_addr_o,
  input wire logic [7:0] slave_rd_addr_o,
  input wire logic cfg_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!hw_rst_low_i);
  // Ends three edges after the release edge, when the decoded straps are due.
  sequence up_s;
    $rose(hw_rst_low_i) ##1 hw_rst_low_i [*3];
  endsequence
  a_reset_holds: assert property (disable iff (1'b0)
    !hw_rst_low_i |=> !cfg_valid_o && pad_oe_o == '0 && rdata_o == '0) else $error("reset leak");
  a_valid_rise: assert property (up_s |-> cfg_valid_o) else $error("late valid");
  a_fmt_capture: assert property (
    up_s |-> ttl_fmt_o == $past(pad_in_i[STRAP_PIN_3], 3)) else $error("format");
  a_boot_window: assert property (
    up_s |-> ext_boot_o == $past(pad_in_i[STRAP_PIN_4], 3) && rom_en_o != ext_boot_o
    && boot_window_kb_o == (ext_boot_o ? FLASH_WINDOW_KB : ROM_WINDOW_KB)) else $error("boot");
  a_width_pick: assert property (up_s |-> channels_o == (ttl_fmt_o ?
    ($past(pad_in_i[STRAP_PIN_5], 3) ? CHAN_DUAL : CHAN_SINGLE) :
    ($past(pad_in_i[STRAP_PIN_5], 3) ? CHAN_QUAD : CHAN_DUAL))) else $error("width");
  a_seed_capture: assert property (
    up_s |-> alt_scrambler_seed_en_o == $past(pad_in_i[STRAP_PIN_6], 3)) else $error("seed");
  a_addr_pair: assert property (up_s |-> slave_wr_addr_o ==
    ($past(pad_in_i[STRAP_PIN_7], 3) ? SLAVE_WR_ADDR_1 : SLAVE_WR_ADDR_0)
    && slave_rd_addr_o == slave_wr_addr_o + 8'h01) else $error("address");
  a_straps_stable: assert property (cfg_valid_o && $past(cfg_valid_o) |->
    $stable({ttl_fmt_o, ext_boot_o, channels_o, alt_scrambler_seed_en_o, slave_wr_addr_o}))
    else $error("straps moved");
  a_shared_func: assert property (cfg_valid_o && $past(cfg_valid_o)
    && fw_claim_i == '0 && $past(fw_claim_i) == '0 && $past(fw_claim_i, 2) == '0
    |-> (pad_oe_o & ~DEDICATED_MASK) == ($past(func_oe_i) & ~DEDICATED_MASK))
    else $error("shared pin");
  c_ttl: cover property (up_s ##0 ttl_fmt_o);
  c_ext: cover property (up_s ##0 ext_boot_o);
  c_claim: cover property (cfg_valid_o && fw_claim_i != '0);
endmodule
bind strap_latch_and_gpio_config strap_cfg_chk u_chk (.clk_i, .hw_rst_low_i, .rdata_o,
  .pad_in_i, .pad_oe_o, .fw_claim_i, .func_oe_i, .ttl_fmt_o, .ext_boot_o, .rom_en_o,
  .boot_window_kb_o, .channels_o, .alt_scrambler_seed_en_o, .slave_wr_addr_o,
  .slave_rd_addr_o, .cfg_valid_o);
`default_nettype wire

// File: board_straps.sv
`timescale 1ns/1ps
`default_nettype none
module board_straps import strap_cfg_pkg::*; (
  input wire logic [7:0] strap_i,
  input wire logic [GPIO_COUNT-1:0] pad_out_i,
  input wire logic [GPIO_COUNT-1:0] pad_oe_i,
  input wire logic [GPIO_COUNT-1:0] ext_i,
  output logic [GPIO_COUNT-1:0] level_o
);
  localparam int PIN [8] = '{STRAP_PIN_0, STRAP_PIN_1, STRAP_PIN_2, STRAP_PIN_3,
    STRAP_PIN_4, STRAP_PIN_5, STRAP_PIN_6, STRAP_PIN_7};
  // Strap resistors win only while the pad is released, so a driven pad hides them.
  always_comb begin
    level_o = ext_i;
    for (int i = 0; i < 8; i++) level_o[PIN[i]] = strap_i[i];
    level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & level_o);
  end
endmodule
`default_nettype wire

// File: tb_strap_latch_and_gpio_config.sv
`timescale 1ns/1ps
`default_nettype none
module tb_strap_latch_and_gpio_config import strap_cfg_pkg::*;;
  logic clk_i = 0, hw_rst_low_i = 0, wr_i = 0, rd_i = 0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0, rdata_o, rv;
  logic [GPIO_COUNT-1:0] pad_in_i, pad_out_o, pad_oe_o, fw_claim_i = '0;
  logic [GPIO_COUNT-1:0] func_out_i = '0, func_oe_i = '0, ext = '0;
  logic [GPIO_COUNT-1:0] func_in_o, gpio_in_o;
  logic ttl_fmt_o, ext_boot_o, rom_en_o, alt_scrambler_seed_en_o, cfg_valid_o;
  logic [9:0] boot_window_kb_o;
  logic [2:0] channels_o;
  logic [7:0] slave_wr_addr_o, slave_rd_addr_o, strap = '0;
  logic [32:0] seen;
  int fails = 0, check_count = 0;
  assign seen = {ttl_fmt_o, ext_boot_o, rom_en_o, boot_window_kb_o, channels_o,
    alt_scrambler_seed_en_o, slave_wr_addr_o, slave_rd_addr_o};
  initial forever #25 clk_i = ~clk_i;
  strap_latch_and_gpio_config dut (.clk_i, .hw_rst_low_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .pad_in_i, .pad_out_o, .pad_oe_o, .fw_claim_i, .func_out_i, .func_oe_i,
    .func_in_o, .gpio_in_o, .ttl_fmt_o, .ext_boot_o, .rom_en_o, .boot_window_kb_o,
    .channels_o, .alt_scrambler_seed_en_o, .slave_wr_addr_o, .slave_rd_addr_o, .cfg_valid_o);
  board_straps bm (.strap_i(strap), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
    .ext_i(ext), .level_o(pad_in_i));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [32:0] ecfg(input logic [7:0] v);
    logic t, b, w;
    logic [2:0] ch;
    logic [7:0] a;
    t = v[SB_VIDEO_FMT];
    b = v[SB_BOOT_SRC];
    w = v[SB_BUS_WIDTH];
    ch = t ? (w ? CHAN_DUAL : CHAN_SINGLE) : (w ? CHAN_QUAD : CHAN_DUAL);
    a = v[SB_SLAVE_ADDR] ? SLAVE_WR_ADDR_1 : SLAVE_WR_ADDR_0;
    return {t, b, !b, b ? FLASH_WINDOW_KB : ROM_WINDOW_KB, ch, v[SB_SEED_MODE], a, a + 8'h01};
  endfunction
  task run(input logic [7:0] v);
    logic [32:0] e;
    e = ecfg(v);
    @(posedge clk_i);
    hw_rst_low_i <= 1'b0;
    fw_claim_i <= '0;
    strap <= v;
    repeat (16) @(posedge clk_i);
    #1 chk({cfg_valid_o, pad_oe_o}, '0);
    @(posedge clk_i);
    hw_rst_low_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    #1 chk(seen[32], e[32]);
    chk(seen[31:20], e[31:20]);
    chk(seen[19:17], e[19:17]);
    chk(seen[16], e[16]);
    chk(seen[15:0], e[15:0]);
    chk(cfg_valid_o, 1'b1);
    rd(ADDR_STRAP);
    chk(rv, 32'h100 | v);
    @(posedge clk_i);
    strap <= ~v;
    ext <= 25'($urandom);
    func_out_i <= 25'($urandom);
    func_oe_i <= 25'($urandom);
    wr(ADDR_CFG, '1);
    rd(ADDR_CFG);
    chk(rv, {1'b0, e[32:17], e[16], e[15:8], 2'b00, e[3:0]});
    chk(seen, e);
    wr(ADDR_DIR, '1);
    wr(ADDR_OUT, '1);
    rd(ADDR_DIR);
    chk(rv, 32'h3);
    settle();
    chk({pad_oe_o, pad_out_o}, {func_oe_i[24:2], 2'b11, func_out_i[24:2], 2'b11});
    wr(ADDR_OD, 32'h1);
    wr(ADDR_OUT_CLR, 32'h1);
    settle();
    chk({pad_oe_o[1:0], pad_out_o[1:0]}, 4'b1110);
    wr(ADDR_OUT_SET, 32'h1);
    settle();
    chk({pad_oe_o[1:0], pad_out_o[1:0]}, 4'b1010);
    rd(ADDR_IN);
    chk(rv, {7'h0, pad_in_i});
    chk({func_in_o, gpio_in_o}, {pad_in_i, pad_in_i});
    rd(ADDR_OD);
    chk(rv, 32'h1);
    rd(ADDR_OUT);
    chk(rv, 32'h3);
    @(posedge clk_i);
    fw_claim_i <= 25'h1 << 20;
    settle();
    wr(ADDR_DIR, '1);
    rd(ADDR_DIR);
    chk(rv, 32'h100003);
    rd(ADDR_SEL);
    chk(rv, 32'h100003);
    rd(8'h40);
    chk(rv, '0);
  endtask
  task final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hdb23dbdd));
    run(8'h00);
    run(8'hff);
    repeat (6) run(8'($urandom));
    final_report();
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
